// file: bench/marker_signal_generator_assertions.sv
// Port-level checks for the marker generator, bound into every instance.
// Assumes one clock, a synchronous high reset and the word map of marker_pkg.
`default_nettype none
module marker_signal_generator_assertions (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic ext_trig_i,
  input wire logic sync_in_i,
  input wire logic [marker_pkg::MARKERS-1:0] marker_o,
  input wire logic trig_mark_o,
  input wire logic running_o
);
  logic wr_q;
  logic [7:0] wa_q;
  logic [31:0] ctrl_q;
  logic [31:0] trig_q;
  logic [2:0] mode0_q;
  wire logic ext_act = ext_trig_i ^ ctrl_q[marker_pkg::CTRL_INV_POL];
  wire logic ext_on = ctrl_q[0] && !ctrl_q[1] && trig_q[4] && trig_q[31:16] == 16'h0000;
  wire logic retrig = trig_q[2:0] == 3'h1;
  wire logic cmd_wr = wr_q && wa_q == marker_pkg::OFS_CMD;
  // Shadow of the settings that decide which trigger paths are live
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_q <= 1'b0;
      wa_q <= 8'h00;
      ctrl_q <= 32'h0000_0000;
      trig_q <= 32'h0000_0000;
      mode0_q <= 3'h0;
    end else begin
      wr_q <= hsel_i && hready_i && htrans_i[1] && hwrite_i;
      wa_q <= haddr_i[7:0];
      if (wr_q && wa_q == marker_pkg::OFS_CTRL) ctrl_q <= hwdata_i;
      if (wr_q && wa_q == marker_pkg::OFS_TRIG) trig_q <= hwdata_i;
      if (wr_q && wa_q == marker_pkg::OFS_MK_BASE) mode0_q <= hwdata_i[2:0];
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ready_okay_a: assert property (hreadyout_o && !hresp_o) else $error("bus answer not zero-wait OKAY");
  reset_quiet_a: assert property (disable iff (1'b0) rst_i |=> marker_o == '0 && !running_o && !trig_mark_o)
    else $error("outputs not cleared by reset");
  stop_quiet_a: assert property (!running_o && !$past(running_o) |-> marker_o == '0)
    else $error("marker active while stopped");
  mark_single_a: assert property (trig_mark_o |=> !trig_mark_o) else $error("trigger mark longer than one cycle");
  ext_event_a: assert property (ext_on && retrig && !trig_q[5] && $rose(ext_act) |-> ##[1:4] trig_mark_o)
    else $error("external edge gave no trigger mark");
  retrig_restart_a: assert property (ext_on && retrig && !trig_q[5] && mode0_q == 3'h0 && $rose(ext_act)
    |-> ##[2:6] marker_o[0]) else $error("retrigger gave no restart pulse");
  restart_once_a: assert property (mode0_q == 3'h0 && marker_o[0] |=> !marker_o[0])
    else $error("restart pulse longer than one symbol");
  sync_event_a: assert property (ctrl_q[0] && ctrl_q[1] && trig_q == 32'h3 && $rose(sync_in_i)
    |-> ##[1:4] trig_mark_o) else $error("sync edge gave no trigger mark");
  arm_stop_a: assert property (cmd_wr && hwdata_i[1:0] == 2'b10 && trig_q[2:0] inside {3'h2, 3'h3}
    |-> ##[1:4] !running_o) else $error("arm did not stop generation");
  suppress_a: assert property (ext_on && trig_q[5] && $rose(ext_act) |=> !trig_mark_o [*4])
    else $error("suppressed edge still triggered");
  cover property (ext_on && retrig && $rose(ext_act));
  cover property (cmd_wr && hwdata_i[1]);
  cover property (ctrl_q[1] && $rose(sync_in_i));
endmodule // marker_signal_generator_assertions
bind marker_signal_generator marker_signal_generator_assertions chk (.clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel_i),
  .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
  .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .ext_trig_i(ext_trig_i), .sync_in_i(sync_in_i),
  .marker_o(marker_o), .trig_mark_o(trig_mark_o), .running_o(running_o));
`default_nettype wire

// file: bench/test_marker_signal_generator.sv
// Self-checking bench for the marker generator: registers, triggers, marker shapes.
// Assumes marker 0 stays in restart mode and serves as the start reference.
`default_nettype none
module test_marker_signal_generator;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [31:0] haddr_i = 32'h0;
  logic [1:0] htrans_i = 2'b00;
  logic hwrite_i = 1'b0;
  logic [31:0] hwdata_i = 32'h0;
  logic [31:0] hrdata_o;
  logic [2:0] marker_o;
  logic hreadyout_o, hresp_o, ext_trig_i, sync_in_i, trig_mark_o, running_o, burst_gate_o, lev_att_o, ramp_o;
  int error_cnt = 0;
  int n_checks = 0;
  int seed = 32'h31400c7e;
  int md[3], dv[3], on[3], of[3], dl[3], pl[3];
  logic [63:0] pat[3];
  logic [4:0] cl[16];
  int clast, t0, t1, i, r, marks = 0, m0;
  logic [31:0] q;
  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) if (trig_mark_o === 1'b1) marks++;
  marker_signal_generator dut (.clk_i(clk_i), .rst_i(rst_i), .hsel_i(1'b1), .haddr_i(haddr_i), .htrans_i(htrans_i),
    .hwrite_i(hwrite_i), .hsize_i(3'b010), .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .ext_trig_i(ext_trig_i), .sync_in_i(sync_in_i),
    .marker_o(marker_o), .trig_mark_o(trig_mark_o), .running_o(running_o), .burst_gate_o(burst_gate_o),
    .lev_att_o(lev_att_o), .ramp_o(ramp_o));
  trig_equipment model (.clk_i(clk_i), .ext_trig_o(ext_trig_i), .sync_o(sync_in_i));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] rq);
    @(posedge clk_i);
    htrans_i <= 2'b10;
    haddr_i <= {24'h0, a};
    hwrite_i <= w;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'b00;
    hwdata_i <= d;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    rq = hrdata_o;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] nq;
    bus(a, 1'b1, d, nq);
  endtask
  function automatic int rnd(input int n);
    return $unsigned($random(seed)) % n;
  endfunction
  function automatic logic expm(input int m, input int k);
    int j;
    j = k - dl[m];
    if (j < 0) return 1'b0;
    case (md[m])
      0: return j == 0;
      1: return ((j / (dv[m] / 2)) % 2) == 0;
      2: return pat[m][j % pl[m]];
      3: return (j % (on[m] + of[m])) < on[m];
      default: return cl[k % (clast + 1)][m];
    endcase
  endfunction
  task automatic cfg(input int m);
    logic [7:0] b;
    b = 8'h20 + 8'(32 * m);
    wr(b + marker_pkg::OFS_MK_MODE, md[m]);
    wr(b + marker_pkg::OFS_MK_DIV, dv[m]);
    wr(b + marker_pkg::OFS_MK_ON, on[m]);
    wr(b + marker_pkg::OFS_MK_OFF, of[m]);
    wr(b + marker_pkg::OFS_MK_DELAY, dl[m]);
    wr(b + marker_pkg::OFS_MK_PLEN, pl[m]);
    wr(b + marker_pkg::OFS_MK_PAT_LO, pat[m][31:0]);
    wr(b + marker_pkg::OFS_MK_PAT_HI, pat[m][63:32]);
  endtask
  // Aligns on the restart pulse of marker 0, then follows all three markers
  task automatic run(input int n, output int t);
    t = 0;
    do begin
      @(posedge clk_i);
      t++;
    end while (marker_o[0] !== 1'b1 && t < 80);
    check(running_o, 1'b1);
    for (int k = 0; k < n; k++) begin
      for (int m = 0; m < 3; m++) check(marker_o[m], expm(m, k));
      check({ramp_o, lev_att_o, burst_gate_o}, {1'b0, cl[k % (clast + 1)][4:3]});
      @(posedge clk_i);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    conclude();
  end
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check({running_o, marker_o}, 4'h0);
    for (i = 0; i < 5; i++) begin
      bus(8'h24 + 8'(4 * i), 1'b0, 0, q);
      check(q, i == 0 ? marker_pkg::RST_DIV : i == 3 ? marker_pkg::RST_WORD
        : i == 4 ? marker_pkg::RST_PLEN : marker_pkg::RST_ONOFF);
    end
    wr(8'h18, 32'hffff_ffff);
    bus(8'h18, 1'b0, 0, q);
    check(q, 32'h0);
    $display("test reset done");
    for (r = 0; r < 4; r++) begin
      md = '{0, 1 + r % 4, 1 + (r + 2) % 4};
      clast = rnd(16);
      for (i = 0; i < 16; i++) begin
        cl[i] = 5'(rnd(32));
        wr(8'h80 + 8'(4 * i), {27'h0, cl[i]});
      end
      wr(marker_pkg::OFS_CONTROL_LIST_MODE, clast);
      for (i = 0; i < 3; i++) begin
        dv[i] = (r == 0) ? 2 : 2 * (1 + rnd(4));
        on[i] = 1 + rnd(4);
        of[i] = 1 + rnd(4);
        dl[i] = (i == 0) ? 0 : rnd(6);
        pl[i] = (r == 3) ? 64 : 1 + rnd(64);
        pat[i] = {32'($random(seed)), 32'($random(seed))};
        cfg(i);
      end
      wr(marker_pkg::OFS_CTRL, 32'h0);
      wr(marker_pkg::OFS_CTRL, 32'h1);
      run(40, t0);
    end
    $display("test modes done");
    wr(marker_pkg::OFS_TRIG, 32'h11);
    // A long hold outlasts the restart pulse, so watch while it is held
    fork
      model.fire(1'b0, 3);
      run(8, t0);
    join
    m0 = marks;
    model.fire(1'b0, 1);
    run(12, t0);
    check(marks - m0, 1);
    i = 1 + rnd(7);
    wr(marker_pkg::OFS_TRIG, 32'h11 | (i << 16));
    model.fire(1'b0, 1);
    run(4, t1);
    check(t1, t0 + i);
    bus(marker_pkg::OFS_STATUS, 1'b0, 0, q);
    check(q[2:0], 3'b101);
    bus(marker_pkg::OFS_STATUS, 1'b0, 0, q);
    check(q[2], 1'b0);
    wr(marker_pkg::OFS_TRIG, 32'h31);
    m0 = marks;
    model.fire(1'b0, 1);
    repeat (10) @(posedge clk_i);
    check(marks - m0, 0);
    wr(marker_pkg::OFS_TRIG, 32'h0);
    wr(marker_pkg::OFS_CTRL, 32'h5);
    model.set_idle(1'b1);
    wr(marker_pkg::OFS_TRIG, 32'h11);
    model.fire(1'b0, 2);
    run(8, t0);
    wr(marker_pkg::OFS_TRIG, 32'h0);
    model.set_idle(1'b0);
    wr(marker_pkg::OFS_CTRL, 32'h1);
    $display("test external done");
    for (r = 1; r < 5; r++) begin
      wr(marker_pkg::OFS_TRIG, r);
      wr(marker_pkg::OFS_CMD, 32'h2);
      wr(marker_pkg::OFS_CMD, 32'h1);
      run(8, t0);
    end
    wr(marker_pkg::OFS_TRIG, 32'h3);
    wr(marker_pkg::OFS_CMD, 32'h2);
    for (t0 = 0; running_o !== 1'b0 && t0 < 10; t0++) @(posedge clk_i);
    repeat (2) @(posedge clk_i);
    for (i = 0; i < 6; i++) begin
      check({running_o, marker_o}, 4'h0);
      @(posedge clk_i);
    end
    bus(marker_pkg::OFS_STATUS, 1'b0, 0, q);
    check(q[1:0], 2'b10);
    wr(marker_pkg::OFS_CTRL, 32'h3);
    model.fire(1'b1, 2);
    run(8, t0);
    $display("test internal and sync done");
    conclude();
  end
endmodule // test_marker_signal_generator
`default_nettype wire

// file: bench/trig_equipment.sv
// Model of the test equipment that triggers the generator through its external and sync inputs.
// Assumes the caller runs its tasks from one process, off the sampling edge.
`default_nettype none
module trig_equipment (
  input wire logic clk_i,
  output logic ext_trig_o,
  output logic sync_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic idle_q = 1'b0;
  initial begin
    ext_trig_o = 1'b0;
    sync_o = 1'b0;
  end
  // Longer holds stand for a slow source; edges line up with the symbol clock
  task automatic fire(input logic use_sync, input int hold);
    @(posedge clk_i);
    if (use_sync) sync_o <= 1'b1; else ext_trig_o <= !idle_q;
    repeat (hold) @(posedge clk_i);
    sync_o <= 1'b0;
    ext_trig_o <= idle_q;
  endtask
  task automatic set_idle(input logic lvl);
    @(posedge clk_i);
    idle_q <= lvl;
    ext_trig_o <= lvl;
  endtask
endmodule // trig_equipment
`default_nettype wire

// file: hdl/marker_pkg.sv
// Package for the marker signal generator: register map, fields, resets, enums.
// Assumes a single 25 MHz clock domain and an AHB-Lite slave with word access.
`default_nettype none
package marker_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TRIG = 8'h04;
  localparam logic [7:0] OFS_CMD = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_RAMP = 8'h10;
  localparam logic [7:0] OFS_CONTROL_LIST_MODE = 8'h14;
  localparam logic [7:0] OFS_MK_BASE = 8'h20;
  localparam logic [7:0] OFS_MK_STRIDE = 8'h20;
  localparam logic [7:0] OFS_MK_MODE = 8'h00;
  localparam logic [7:0] OFS_MK_DIV = 8'h04;
  localparam logic [7:0] OFS_MK_ON = 8'h08;
  localparam logic [7:0] OFS_MK_OFF = 8'h0c;
  localparam logic [7:0] OFS_MK_DELAY = 8'h10;
  localparam logic [7:0] OFS_MK_PLEN = 8'h14;
  localparam logic [7:0] OFS_MK_PAT_LO = 8'h18;
  localparam logic [7:0] OFS_MK_PAT_HI = 8'h1c;
  localparam int unsigned CTRL_MOD_EN = 0;
  localparam int unsigned CTRL_SECONDARY = 1;
  localparam int unsigned CTRL_INV_POL = 2;
  localparam int unsigned TRIG_MODE_LSB = 0;
  localparam int unsigned TRIG_SRC = 4;
  localparam int unsigned TRIG_SUPPRESS = 5;
  localparam int unsigned TRIG_DELAY_LSB = 16;
  localparam int unsigned CMD_EXEC = 0;
  localparam int unsigned CMD_ARM = 1;
  localparam int unsigned ST_RUN = 0;
  localparam int unsigned ST_ARMED = 1;
  localparam int unsigned ST_TRIG_SEEN = 2;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [31:0] RST_DIV = 32'h0000_0002;
  localparam logic [31:0] RST_ONOFF = 32'h0000_0001;
  localparam logic [31:0] RST_PLEN = 32'h0000_0040;
  localparam int unsigned MARKERS = 3;
  localparam int unsigned PATTERN_BITS = 64;
  typedef enum logic [2:0] {
    MK_RESTART,
    MK_PULSE,
    MK_PATTERN,
    MK_ONOFF,
    MK_CONTROL_LIST_MODE
  } marker_mode_t;
  typedef enum logic [2:0] {
    TM_AUTO,
    TM_RETRIGGER,
    TM_ARMED_AUTO,
    TM_ARMED_RETRIGGER,
    TM_SINGLE
  } trig_mode_t;
endpackage
`default_nettype wire

// file: hdl/marker_signal_generator.sv
// Marker signal generator with trigger run/stop control and AHB-Lite registers.
// Assumes one symbol clock clk_i, synchronous inputs and a single AHB master.
// Operation
// (RULE_01) Three independent markers, each with own mode and settings, to user connectors.
// (RULE_02) Restart mode: one high pulse at generation start and each restart.
// (RULE_03) Pulse mode: equal high and low phases, high first at first symbol.
// (RULE_04) Pulse mode: each phase lasts divider/2 symbol periods.
// (RULE_05) Pattern mode repeats up to 64 bits, one bit per symbol.
// (RULE_06) Pattern bit 1 drives high, 0 drives low, for one symbol.
// (RULE_07) On/off mode: independent high and low phase lengths in symbols.
// (RULE_08) Control-list mode: marker follows the selected control list entry per symbol.
// (RULE_09) Without delay, markers begin at the first generated symbol.
// (RULE_10) Marker start may be postponed by a programmable symbol count.
// (RULE_11) Without triggering, generation starts right after modulation is enabled.
// (RULE_12) Trigger event comes from a trigger signal or a manual command.
// (RULE_13) Arm halts generation until the next trigger event.
// (RULE_14) Sources internal and external global; secondary mode forces sync input edge.
// (RULE_15) Trigger mode, source, delay and suppression are independent settings.
// (RULE_16) External trigger polarity applies identically to every user of the input.
// (RULE_17) Running or stopped state is always reported.
// (RULE_18) A trigger event marker can drive a user connector.
// (RULE_19) Burst gate marks ramp starts; level attenuation marks attenuation span.
// (RULE_20) Ramp time programmable; rise and fall delays shift envelope edges.
// (RULE_21) All signals sampled and aligned on the rising clock edge.
// (RULE_22) Retrigger: trigger while running restarts generation and all markers.
// (RULE_23) Markers held low while stopped or armed.
`default_nettype none
module marker_signal_generator #(
  parameter int unsigned CNT_W = 16,
  parameter int unsigned CONTROL_LIST_MODE_DEPTH = 64
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic ext_trig_i,
  input wire logic sync_in_i,
  output logic [marker_pkg::MARKERS-1:0] marker_o,
  output logic trig_mark_o,
  output logic running_o,
  output logic burst_gate_o,
  output logic lev_att_o,
  output logic ramp_o
);
  localparam int unsigned AW = $clog2(CONTROL_LIST_MODE_DEPTH);
  // Bus address phase capture
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [31:0] rdata_q;
  wire addr_ok = hsel_i && hready_i && htrans_i[1];
  wire [7:0] a8 = haddr_i[7:0];
  wire do_wr = wr_pend_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= addr_ok && hwrite_i;
      wr_addr_q <= a8;
    end
  end
  // Registers
  logic [31:0] ctrl_q;
  logic [31:0] trig_q;
  logic [31:0] ramp_q;
  logic [31:0] mk_mode_q [marker_pkg::MARKERS];
  logic [31:0] mk_div_q [marker_pkg::MARKERS];
  logic [31:0] mk_on_q [marker_pkg::MARKERS];
  logic [31:0] mk_off_q [marker_pkg::MARKERS];
  logic [31:0] mk_dly_q [marker_pkg::MARKERS];
  logic [31:0] mk_plen_q [marker_pkg::MARKERS];
  logic [63:0] mk_pat_q [marker_pkg::MARKERS];
  logic [4:0] control_list_mode_mem [CONTROL_LIST_MODE_DEPTH];
  logic [AW-1:0] control_list_mode_len_q;
  wire wr_ctrl = do_wr && wr_addr_q == marker_pkg::OFS_CTRL;
  wire wr_trig = do_wr && wr_addr_q == marker_pkg::OFS_TRIG;
  wire wr_cmd = do_wr && wr_addr_q == marker_pkg::OFS_CMD;
  wire wr_ramp = do_wr && wr_addr_q == marker_pkg::OFS_RAMP;
  // Control list entries sit at 0x80 and above, one word each
  wire wr_control_list_mode = do_wr && wr_addr_q[7];
  wire wr_clen = do_wr && wr_addr_q == marker_pkg::OFS_CONTROL_LIST_MODE;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= marker_pkg::RST_WORD;
      trig_q <= marker_pkg::RST_WORD;
      ramp_q <= marker_pkg::RST_WORD;
      control_list_mode_len_q <= '0;
    end else begin
      if (wr_ctrl) ctrl_q <= hwdata_i;
      if (wr_trig) trig_q <= hwdata_i; // RULE_15
      if (wr_ramp) ramp_q <= hwdata_i; // RULE_20
      if (wr_clen) control_list_mode_len_q <= hwdata_i[AW-1:0];
    end
  end
  // Bit 7 only selects the list window, so at most 32 entries are reachable
  always_ff @(posedge clk_i) begin
    if (wr_control_list_mode) control_list_mode_mem[AW'(wr_addr_q[6:2])] <= hwdata_i[4:0];
  end
  // Trigger control
  wire mod_en = ctrl_q[marker_pkg::CTRL_MOD_EN];
  wire secondary = ctrl_q[marker_pkg::CTRL_SECONDARY];
  wire [2:0] tmode = trig_q[marker_pkg::TRIG_MODE_LSB +: 3];
  wire [15:0] ext_delay = trig_q[marker_pkg::TRIG_DELAY_LSB +: 16];
  logic ext_lvl_q;
  logic sync_lvl_q;
  // One polarity setting shared by every consumer of the external input
  wire ext_pol = ext_trig_i ^ ctrl_q[marker_pkg::CTRL_INV_POL]; // RULE_16
  wire ext_edge = ext_pol && !ext_lvl_q;
  wire sync_edge = sync_in_i && !sync_lvl_q;
  wire ext_src = secondary ? sync_edge : (trig_q[marker_pkg::TRIG_SRC] && ext_edge); // RULE_14
  wire ext_ok = ext_src && !trig_q[marker_pkg::TRIG_SUPPRESS];
  wire cmd_exec = wr_cmd && hwdata_i[marker_pkg::CMD_EXEC];
  wire cmd_arm = wr_cmd && hwdata_i[marker_pkg::CMD_ARM];
  logic [15:0] edly_q;
  logic edly_busy_q;
  wire ext_fire = edly_busy_q && edly_q == 16'h0000;
  wire ext_now = ext_ok && ext_delay == 16'h0000;
  wire int_src = !secondary && !trig_q[marker_pkg::TRIG_SRC];
  wire trig_ev = (int_src && cmd_exec) || ext_now || ext_fire; // RULE_12
  logic run_q;
  logic armed_q;
  logic mod_en_q;
  wire auto_m = tmode == marker_pkg::TM_AUTO;
  wire armed_m = tmode == marker_pkg::TM_ARMED_AUTO || tmode == marker_pkg::TM_ARMED_RETRIGGER;
  wire retrig_ok = tmode != marker_pkg::TM_ARMED_AUTO || armed_q;
  wire auto_start = mod_en && !mod_en_q && auto_m; // RULE_11
  wire restart = mod_en && (auto_start || (!auto_m && trig_ev && (!run_q || retrig_ok))); // RULE_22
  wire stop = !mod_en || (cmd_arm && armed_m); // RULE_13
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_lvl_q <= 1'b0;
      sync_lvl_q <= 1'b0;
      edly_q <= 16'h0000;
      edly_busy_q <= 1'b0;
      run_q <= 1'b0;
      armed_q <= 1'b0;
      mod_en_q <= 1'b0;
    end else begin
      ext_lvl_q <= ext_pol;
      sync_lvl_q <= sync_in_i;
      mod_en_q <= mod_en;
      if (ext_ok && ext_delay != 16'h0000) begin
        edly_busy_q <= 1'b1;
        edly_q <= ext_delay - 16'h0001;
      end else if (edly_busy_q) begin
        edly_busy_q <= edly_q != 16'h0000;
        edly_q <= edly_q - 16'h0001;
      end
      if (stop) begin
        run_q <= 1'b0;
        armed_q <= cmd_arm;
      end else if (restart) begin
        run_q <= 1'b1;
        armed_q <= 1'b0;
      end
    end
  end
  // Symbol index for the control list
  logic [AW-1:0] cl_idx_q;
  wire [AW-1:0] cl_nidx = (cl_idx_q == control_list_mode_len_q) ? '0 : cl_idx_q + 1'b1;
  wire [4:0] cl_word = control_list_mode_mem[cl_idx_q];
  // Markers register one symbol ahead, so they look at the next entry
  wire [4:0] cl_nx = control_list_mode_mem[cl_nidx];
  wire [4:0] cl_head = control_list_mode_mem[0];
  always_ff @(posedge clk_i) begin
    if (rst_i || restart) cl_idx_q <= '0;
    else if (run_q) cl_idx_q <= cl_nidx;
  end
  // Per-marker engines
  logic [marker_pkg::MARKERS-1:0] mk_q;
  genvar g;
  generate
    for (g = 0; g < marker_pkg::MARKERS; g++) begin : g_mk // RULE_01
      localparam logic [7:0] BASE = 8'(marker_pkg::OFS_MK_BASE + g * marker_pkg::OFS_MK_STRIDE);
      wire sel = do_wr && wr_addr_q[7:5] == BASE[7:5];
      wire [7:0] off = {3'b000, wr_addr_q[4:0]};
      logic [CNT_W-1:0] dly_q;
      logic [CNT_W-1:0] cnt_q;
      logic [5:0] bit_q;
      logic lvl_q;
      logic act_q;
      wire [2:0] mode = mk_mode_q[g][2:0];
      wire [CNT_W-1:0] half = CNT_W'(mk_div_q[g] >> 1);
      wire [CNT_W-1:0] on_t = mk_on_q[g][CNT_W-1:0];
      wire [CNT_W-1:0] off_t = mk_off_q[g][CNT_W-1:0];
      wire [CNT_W-1:0] dly = mk_dly_q[g][CNT_W-1:0];
      wire [5:0] plen_m1 = 6'(mk_plen_q[g] - 32'h1);
      logic nxt;
      always_comb begin
        nxt = 1'b0;
        case (mode)
          marker_pkg::MK_RESTART: nxt = 1'b0; // RULE_02
          marker_pkg::MK_PULSE: nxt = (cnt_q + 1'b1 >= half) ? !lvl_q : lvl_q; // RULE_03 RULE_04
          marker_pkg::MK_PATTERN: nxt = mk_pat_q[g][bit_q == plen_m1 ? 6'd0 : bit_q + 6'd1]; // RULE_05
          marker_pkg::MK_ONOFF: nxt = (cnt_q + 1'b1 >= (lvl_q ? on_t : off_t)) ? !lvl_q : lvl_q; // RULE_07
          marker_pkg::MK_CONTROL_LIST_MODE: nxt = cl_nx[g]; // RULE_08
          default: nxt = 1'b0;
        endcase
      end
      wire first = mode == marker_pkg::MK_PATTERN ? mk_pat_q[g][0]
                 : mode == marker_pkg::MK_CONTROL_LIST_MODE ? cl_head[g] : 1'b1;
      // A delayed list marker joins the shared list at the current symbol
      wire resume = mode == marker_pkg::MK_CONTROL_LIST_MODE ? nxt : first;
      wire flip = mode == marker_pkg::MK_PULSE ? cnt_q + 1'b1 >= half
                : mode == marker_pkg::MK_ONOFF && cnt_q + 1'b1 >= (lvl_q ? on_t : off_t);
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          mk_mode_q[g] <= marker_pkg::RST_WORD;
          mk_div_q[g] <= marker_pkg::RST_DIV;
          mk_on_q[g] <= marker_pkg::RST_ONOFF;
          mk_off_q[g] <= marker_pkg::RST_ONOFF;
          mk_dly_q[g] <= marker_pkg::RST_WORD;
          mk_plen_q[g] <= marker_pkg::RST_PLEN;
          mk_pat_q[g] <= 64'h0;
        end else if (sel) begin
          if (off == marker_pkg::OFS_MK_MODE) mk_mode_q[g] <= hwdata_i;
          if (off == marker_pkg::OFS_MK_DIV) mk_div_q[g] <= hwdata_i;
          if (off == marker_pkg::OFS_MK_ON) mk_on_q[g] <= hwdata_i;
          if (off == marker_pkg::OFS_MK_OFF) mk_off_q[g] <= hwdata_i;
          if (off == marker_pkg::OFS_MK_DELAY) mk_dly_q[g] <= hwdata_i; // RULE_10
          if (off == marker_pkg::OFS_MK_PLEN) mk_plen_q[g] <= hwdata_i;
          if (off == marker_pkg::OFS_MK_PAT_LO) mk_pat_q[g][31:0] <= hwdata_i;
          if (off == marker_pkg::OFS_MK_PAT_HI) mk_pat_q[g][63:32] <= hwdata_i;
        end
      end
      always_ff @(posedge clk_i) begin // RULE_21
        if (rst_i || stop) begin
          act_q <= 1'b0;
          lvl_q <= 1'b0;
          dly_q <= '0;
          cnt_q <= '0;
          bit_q <= 6'd0;
        end else if (restart) begin // RULE_22
          act_q <= dly == '0; // RULE_09
          dly_q <= dly;
          lvl_q <= dly == '0 ? first : 1'b0;
          cnt_q <= '0;
          bit_q <= 6'd0;
        end else if (run_q && !act_q) begin
          act_q <= dly_q == CNT_W'(1);
          dly_q <= dly_q - 1'b1;
          lvl_q <= dly_q == CNT_W'(1) ? resume : 1'b0;
        end else if (run_q) begin
          lvl_q <= nxt; // RULE_06
          cnt_q <= flip ? '0 : cnt_q + 1'b1;
          bit_q <= bit_q == plen_m1 ? 6'd0 : bit_q + 6'd1;
        end
      end
      assign mk_q[g] = lvl_q && run_q; // RULE_23
    end
  endgenerate
  // Status and register readback
  logic trig_seen_q;
  wire [31:0] status_w = {29'h0, trig_seen_q, armed_q, run_q}; // RULE_17
  wire [2:0] rd_mk = a8[7:5] - 3'd1;
  wire rd_is_mk = a8 >= marker_pkg::OFS_MK_BASE && a8 < 8'h80;
  wire [31:0] rd_mk_w = a8[4:0] == 5'h00 ? mk_mode_q[rd_mk[1:0]]
                      : a8[4:0] == 5'h04 ? mk_div_q[rd_mk[1:0]]
                      : a8[4:0] == 5'h08 ? mk_on_q[rd_mk[1:0]]
                      : a8[4:0] == 5'h0c ? mk_off_q[rd_mk[1:0]]
                      : a8[4:0] == 5'h10 ? mk_dly_q[rd_mk[1:0]]
                      : a8[4:0] == 5'h14 ? mk_plen_q[rd_mk[1:0]]
                      : a8[4:0] == 5'h18 ? mk_pat_q[rd_mk[1:0]][31:0]
                      : mk_pat_q[rd_mk[1:0]][63:32];
  wire [31:0] rd_w = a8 == marker_pkg::OFS_CTRL ? ctrl_q
                   : a8 == marker_pkg::OFS_TRIG ? trig_q
                   : a8 == marker_pkg::OFS_STATUS ? status_w
                   : a8 == marker_pkg::OFS_RAMP ? ramp_q
                   : a8 == marker_pkg::OFS_CONTROL_LIST_MODE ? 32'(control_list_mode_len_q)
                   : rd_is_mk ? rd_mk_w
                   : 32'h0000_0000;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q <= 32'h0000_0000;
      trig_seen_q <= 1'b0;
    end else begin
      if (addr_ok && !hwrite_i) rdata_q <= rd_w;
      // Reading status clears it, but a new event in that cycle wins
      if (trig_ev) trig_seen_q <= 1'b1;
      else if (addr_ok && !hwrite_i && a8 == marker_pkg::OFS_STATUS) trig_seen_q <= 1'b0;
    end
  end
  // Ramp edges: burst gate from control list bit 3, attenuation from bit 4
  logic [15:0] ramp_cnt_q;
  logic gate_q;
  wire gate_now = run_q && cl_word[3];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      marker_o <= '0;
      trig_mark_o <= 1'b0;
      running_o <= 1'b0;
      burst_gate_o <= 1'b0;
      lev_att_o <= 1'b0;
      ramp_o <= 1'b0;
      gate_q <= 1'b0;
      ramp_cnt_q <= 16'h0000;
    end else begin
      marker_o <= mk_q;
      trig_mark_o <= trig_ev; // RULE_18
      running_o <= run_q;
      burst_gate_o <= gate_now; // RULE_19
      lev_att_o <= run_q && cl_word[4];
      gate_q <= gate_now;
      // Delay then ramp duration, restarted on every gate transition
      if (gate_now != gate_q) ramp_cnt_q <= (gate_now ? ramp_q[31:24] : ramp_q[23:16]) + ramp_q[15:0]; // RULE_20
      else if (ramp_cnt_q != 16'h0000) ramp_cnt_q <= ramp_cnt_q - 16'h0001;
      ramp_o <= ramp_cnt_q != 16'h0000 && ramp_cnt_q <= ramp_q[15:0];
    end
  end
  assign hrdata_o = rdata_q;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
endmodule // marker_signal_generator
`default_nettype wire
